/* src/cg_pkg.sv */
// Purpose : Shared constants for the processor clock generator
// Assumes : One 200 MHz reference clock, all pins asynchronous to it
// Notes   : Pin indices address the synchroniser bank vector
package cg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int REF_CLK_MHZ     = 200;
  localparam int SRC_MAX_MHZ     = 25;   // Highest source rate sampled cleanly
  // Reference cycles per source period at the highest rate, rounded down
  localparam int SRC_MIN_CYCLES  = REF_CLK_MHZ / SRC_MAX_MHZ;
  localparam int SYNC_DEPTH      = 2;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  localparam logic [1:0] DIV_LAST   = 2'h2;  // Divide by three: counts 0..2
  localparam logic [1:0] DIV_HIGH   = 2'h0;  // Count during which the clock is high
  localparam logic [1:0] DIV_RESET  = 2'h2;  // Next edge after a clear raises the clock
  // Edges before the strap has crossed both stages; the second stage fills one edge late
  localparam logic [1:0] WARM_DONE  = 2'h3;

  // ----------------------------------------------------------------
  // Synchroniser bank layout
  // ----------------------------------------------------------------
  localparam int PIN_XTAL   = 0;
  localparam int PIN_EXT    = 1;
  localparam int PIN_RES_N  = 2;
  localparam int PIN_RDY_A  = 3;
  localparam int PIN_RDY_B  = 4;
  localparam int PIN_QUAL_A = 5;
  localparam int PIN_QUAL_B = 6;
  localparam int PIN_STAGE  = 7;
  localparam int PIN_CLEAR  = 8;
  localparam int PIN_STRAP  = 9;
  localparam int PIN_COUNT  = 10;

endpackage

/* src/cg_sync_if.sv */
// Purpose : Carrier between the pin synchroniser and the generator core
// Assumes : Raw pins are asynchronous to the reference clock
// Notes   : Width follows the pin count of the package
interface cg_sync_if #(parameter int W = 10);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport sync_side (input raw, output synced);
  modport core_side (output raw, input synced);
endinterface

/* src/cg_pin_sync.sv */
// Purpose : Two flip-flop synchroniser for every asynchronous pin
// Assumes : Single reference clock, asynchronous active high reset
// Notes   : The first stage is read only by the second stage
module cg_pin_sync
  import cg_pkg::*;
#(
  parameter int W = PIN_COUNT
) (
  input  wire logic clk,
  input  wire logic rst,
  cg_sync_if.sync_side pins
);

  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } cg_sync_state_t;

  cg_sync_state_t st;
  cg_sync_state_t next_st;

  // ----------------------------------------------------------------
  // Metastability chain
  // ----------------------------------------------------------------
  // Shift each pin through two stages
  always_comb begin
    next_st.first  = pins.raw;
    next_st.second = st.first;
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pins.synced = st.second;

endmodule

/* src/cg_clock_gen.sv */
// Purpose : Processor clock generator with reset and ready synchronisation
// Assumes : Source rates up to 25 MHz, sampled by a 200 MHz reference clock
// Notes   : All generated clocks are registered levels, not derived clocks
//
// Functional notes
// - Strap low selects crystal oscillator, high selects external frequency input.
// - Processor clock is one third of source frequency, one third duty.
// - Counter is static: works for any source rate from zero to maximum.
// - Reset output follows reset input; low input requests reset.
// - Each active-low qualifier validates its own bus-ready input.
// - Stage select low gives two sync stages, high gives one.
// - Ready output is active high, synchronised, deasserting after hold time.
// - Peripheral clock is half the processor clock with equal high/low.
// - Counter-clear input high holds divide counters reset; low resumes counting.
// - Reset output updates on processor clock falling edge.
// - Two-stage: rising ready caught at clock rise then fall; falling only at fall.
module cg_clock_gen
  import cg_pkg::*;
(
  input  wire logic REF_CLK,
  input  wire logic SYS_RST,
  input  wire logic CRYSTAL_PIN_A,
  input  wire logic EXTERNAL_FREQ_IN,
  input  wire logic FREQ_SOURCE_SELECT,
  input  wire logic RESET_IN_N,
  input  wire logic BUS_READY_A,
  input  wire logic BUS_READY_B,
  input  wire logic READY_QUALIFIER_A_N,
  input  wire logic READY_QUALIFIER_B_N,
  input  wire logic SYNC_STAGE_SELECT,
  input  wire logic COUNTER_CLEAR_SYNC,
  output logic      CRYSTAL_PIN_B,
  output logic      OSCILLATOR_OUT,
  output logic      CPU_CLK,
  output logic      PERIPH_CLK,
  output logic      RESET_OUT,
  output logic      READY
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  cg_sync_if #(.W(PIN_COUNT)) pins ();

  // Every pin is asynchronous, so all of them pass the two-stage bank
  assign pins.raw[PIN_XTAL]   = CRYSTAL_PIN_A;
  assign pins.raw[PIN_EXT]    = EXTERNAL_FREQ_IN;
  assign pins.raw[PIN_RES_N]  = RESET_IN_N;
  assign pins.raw[PIN_RDY_A]  = BUS_READY_A;
  assign pins.raw[PIN_RDY_B]  = BUS_READY_B;
  assign pins.raw[PIN_QUAL_A] = READY_QUALIFIER_A_N;
  assign pins.raw[PIN_QUAL_B] = READY_QUALIFIER_B_N;
  assign pins.raw[PIN_STAGE]  = SYNC_STAGE_SELECT;
  assign pins.raw[PIN_CLEAR]  = COUNTER_CLEAR_SYNC;
  assign pins.raw[PIN_STRAP]  = FREQ_SOURCE_SELECT;

  cg_pin_sync #(.W(PIN_COUNT)) u_sync (
    .clk  (REF_CLK),
    .rst  (SYS_RST),
    .pins (pins)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] warm;      // Cycles since reset release, saturating
    logic       strap;     // Source select caught once after reset
    logic       src_prev;  // Previous level of the selected source
    logic       xtal_buf;  // Buffered oscillator level
    logic [1:0] cnt;       // Divide-by-three position
    logic       cpu_clk;
    logic       periph;
    logic       reset_out;
    logic       stage1;    // First ready flip-flop, taken at clock rise
    logic       ready;     // Second ready flip-flop, taken at clock fall
  } cg_state_t;

  cg_state_t st;
  cg_state_t next_st;

  // Ready qualification, shared by logic and checks
  function automatic logic qualify(input logic rdy_a, input logic qa_n,
                                   input logic rdy_b, input logic qb_n);
    return (rdy_a & ~qa_n) | (rdy_b & ~qb_n);
  endfunction

  logic s_xtal;
  logic s_ext;
  logic s_res_n;
  logic s_single;
  logic s_clear;
  logic q_rdy;
  logic src_lvl;
  logic src_edge;
  logic clk_rise;
  logic clk_fall;

  assign s_xtal   = pins.synced[PIN_XTAL];
  assign s_ext    = pins.synced[PIN_EXT];
  assign s_res_n  = pins.synced[PIN_RES_N];
  assign s_single = pins.synced[PIN_STAGE];
  assign s_clear  = pins.synced[PIN_CLEAR];
  assign q_rdy    = qualify(pins.synced[PIN_RDY_A], pins.synced[PIN_QUAL_A],
                            pins.synced[PIN_RDY_B], pins.synced[PIN_QUAL_B]);

  // ----------------------------------------------------------------
  // Source selection and edge detection
  // ----------------------------------------------------------------
  // Only edges advance the divider, so a stopped source simply freezes it
  assign src_lvl  = st.strap ? s_ext : s_xtal;
  assign src_edge = (st.warm == WARM_DONE) && src_lvl && !st.src_prev;

  // Clock transitions this cycle, taken from the next divider state
  assign clk_rise = next_st.cpu_clk && !st.cpu_clk;
  assign clk_fall = !next_st.cpu_clk && st.cpu_clk;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.xtal_buf = s_xtal;
    next_st.src_prev = src_lvl;
    // Strap is read once the synchroniser has filled with real pin levels
    if (st.warm != WARM_DONE) begin
      next_st.warm = st.warm + 2'h1;
      if (st.warm + 2'h1 == WARM_DONE) begin
        next_st.strap = pins.synced[PIN_STRAP];
      end
    end
    // Divider: clear holds it parked so the first edge after release raises CLK
    if (s_clear) begin
      next_st.cnt     = DIV_RESET;
      next_st.cpu_clk = 1'b0;
      next_st.periph  = 1'b0;
    end else if (src_edge) begin
      next_st.cnt     = (st.cnt == DIV_LAST) ? DIV_HIGH : st.cnt + 2'h1;
      next_st.cpu_clk = (next_st.cnt == DIV_HIGH);
      if (next_st.cnt == DIV_HIGH) begin
        next_st.periph = !st.periph;
      end
    end
    // Reset and ready flip-flops act on the clock transitions just computed
    if (!next_st.cpu_clk && st.cpu_clk) begin
      next_st.reset_out = !s_res_n;
      // Falling input passes straight through; rising needs stage one as well in two-stage mode
      next_st.ready = s_single ? q_rdy : (q_rdy && st.stage1);
    end
    // Stage one only matters in two-stage mode; it samples at every rise
    if (next_st.cpu_clk && !st.cpu_clk) begin
      next_st.stage1 = q_rdy;
    end
  end

  // State register; reset output asserted while the block is in reset
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st           <= '0;
      st.cnt       <= DIV_RESET;
      st.reset_out <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign CPU_CLK        = st.cpu_clk;
  assign PERIPH_CLK     = st.periph;
  assign RESET_OUT      = st.reset_out;
  assign READY          = st.ready;
  assign OSCILLATOR_OUT = st.xtal_buf;
  assign CRYSTAL_PIN_B  = !st.xtal_buf; // Inverting drive back to the crystal

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_last_edge;
    src_edge && !s_clear && st.cnt == DIV_LAST;
  endsequence

  sequence s_two_stage_arm;
    clk_rise && !s_single && q_rdy;
  endsequence

  // A rise of the strapped source must move the divider unless clear is held
  property p_src_select;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (st.warm == WARM_DONE && !s_clear && (st.strap ? s_ext : s_xtal) &&
       !$past(src_lvl)) |=> st.cnt != $past(st.cnt);
  endproperty
  a_src_select: assert property (p_src_select) else $error("source edge lost");

  property p_clk_high_third;
    @(posedge REF_CLK) disable iff (SYS_RST)
      s_last_edge |=> CPU_CLK && st.cnt == DIV_HIGH;
  endproperty
  a_clk_high_third: assert property (p_clk_high_third) else $error("clk not raised");

  property p_clk_low_two;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (src_edge && !s_clear && st.cnt == DIV_HIGH) |=> !CPU_CLK ##1 !CPU_CLK;
  endproperty
  a_clk_low_two: assert property (p_clk_low_two) else $error("clk high too long");

  property p_periph_half;
    @(posedge REF_CLK) disable iff (SYS_RST)
      $rose(CPU_CLK) |-> PERIPH_CLK != $past(PERIPH_CLK);
  endproperty
  a_periph_half: assert property (p_periph_half) else $error("pclk missed toggle");

  property p_clear_hold;
    @(posedge REF_CLK) disable iff (SYS_RST)
      s_clear |=> !CPU_CLK && !PERIPH_CLK && st.cnt == DIV_RESET;
  endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("clear not holding");

  property p_reset_on_fall;
    @(posedge REF_CLK) disable iff (SYS_RST)
      $changed(RESET_OUT) |-> $fell(CPU_CLK);
  endproperty
  a_reset_on_fall: assert property (p_reset_on_fall) else $error("reset off edge");

  property p_reset_follow;
    @(posedge REF_CLK) disable iff (SYS_RST)
      clk_fall |=> RESET_OUT == !$past(s_res_n);
  endproperty
  a_reset_follow: assert property (p_reset_follow) else $error("reset wrong level");

  sequence s_two_stage_fire;
    clk_fall && !s_single && q_rdy && st.stage1;
  endsequence

  property p_two_stage;
    @(posedge REF_CLK) disable iff (SYS_RST)
      s_two_stage_arm |=> st.stage1;
  endproperty
  a_two_stage: assert property (p_two_stage) else $error("stage one not armed");

  property p_two_stage_fire;
    @(posedge REF_CLK) disable iff (SYS_RST)
      s_two_stage_fire |=> READY;
  endproperty
  a_two_stage_fire: assert property (p_two_stage_fire) else $error("ready not raised");

  // Without stage one armed at the rise, two-stage mode must hold ready low
  property p_two_stage_block;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (clk_fall && !s_single && !st.stage1) |=> !READY;
  endproperty
  a_two_stage_block: assert property (p_two_stage_block) else $error("ready too early");

  property p_ready_fall;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (clk_fall && !q_rdy) |=> !READY;
  endproperty
  a_ready_fall: assert property (p_ready_fall) else $error("ready not dropped");

  property p_single_stage;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (clk_fall && s_single) |=> READY == $past(q_rdy);
  endproperty
  a_single_stage: assert property (p_single_stage) else $error("single stage wrong");

  property p_ready_drop;
    @(posedge REF_CLK) disable iff (SYS_RST)
      $fell(READY) |-> $fell(CPU_CLK);
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready dropped early");

  property p_qualifier;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (clk_fall && s_single && pins.synced[PIN_QUAL_A] && pins.synced[PIN_QUAL_B]) |=> !READY;
  endproperty
  a_qualifier: assert property (p_qualifier) else $error("unqualified ready");

endmodule

/* verification/cg_far_end.sv */
// Purpose : Far side model: clock sources and two system-bus ready devices
// Assumes : Everything moves on the reference clock falling edge
// Notes   : Source periods are whole reference cycles so widths are exact
module cg_far_end #(
  parameter int XTAL_HALF = 4,
  parameter int EXT_HALF  = 40
) (
  input  wire logic clk,
  input  wire logic want_a,
  input  wire logic want_b,
  input  wire logic off_a,
  input  wire logic off_b,
  output logic      xtal,
  output logic      ext_freq,
  output logic      rdy_a,
  output logic      rdy_b,
  output logic      qual_a_n,
  output logic      qual_b_n
);
  timeunit 1ns;
  timeprecision 100ps;
  int xcnt;
  int ecnt;

  // Known levels from time zero, before the first falling edge
  initial begin
    {xtal, ext_freq, rdy_a, rdy_b, qual_a_n, qual_b_n} = 6'h00;
    xcnt = 0;
    ecnt = 0;
  end

  // Square waves at three times the wanted processor clock
  always @(negedge clk) begin
    xcnt <= (xcnt == XTAL_HALF - 1) ? 0 : xcnt + 1;
    ecnt <= (ecnt == EXT_HALF - 1) ? 0 : ecnt + 1;
    if (xcnt == XTAL_HALF - 1) xtal <= ~xtal;
    if (ecnt == EXT_HALF - 1) ext_freq <= ~ext_freq;
  end

  // Ready goes high for data taken; qualifiers stay low unless a master lets go
  always @(negedge clk) begin
    rdy_a    <= want_a;
    rdy_b    <= want_b;
    qual_a_n <= off_a;
    qual_b_n <= off_b;
  end
endmodule

/* verification/testbench.sv */
// Purpose : Self-checking bench for the processor clock generator
// Assumes : Inputs move on the reference clock falling edge
// Notes   : Widths are counted in reference cycles at falling edges
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int XH = 4;
  localparam int EH = 40;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic strap = 1'b0;
  logic res_n = 1'b1;
  logic stage = 1'b1;
  logic clear = 1'b0;
  logic want_a = 1'b0, want_b = 1'b0, off_a = 1'b0, off_b = 1'b0;
  logic xtal, ext_freq, rdy_a, rdy_b, qa_n, qb_n;
  logic cpu_clk, periph_clk, reset_out, ready, prev_cpu, prev_rst, prev_rdy;
  logic osc_out, xtal_b;
  int   bad_count = 0;
  int   total_checks = 0;
  bit   mon_on = 1'b0;

  always #2.5 ref_clk = ~ref_clk;

  cg_far_end #(.XTAL_HALF(XH), .EXT_HALF(EH)) u_cg_far_end (
    .clk(ref_clk), .want_a(want_a), .want_b(want_b), .off_a(off_a),
    .off_b(off_b), .xtal(xtal), .ext_freq(ext_freq), .rdy_a(rdy_a),
    .rdy_b(rdy_b), .qual_a_n(qa_n), .qual_b_n(qb_n));

  cg_clock_gen u_cg_clock_gen (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .CRYSTAL_PIN_A(xtal),
    .EXTERNAL_FREQ_IN(ext_freq), .FREQ_SOURCE_SELECT(strap),
    .RESET_IN_N(res_n), .BUS_READY_A(rdy_a), .BUS_READY_B(rdy_b),
    .READY_QUALIFIER_A_N(qa_n), .READY_QUALIFIER_B_N(qb_n),
    .SYNC_STAGE_SELECT(stage), .COUNTER_CLEAR_SYNC(clear),
    .CRYSTAL_PIN_B(xtal_b), .OSCILLATOR_OUT(osc_out), .CPU_CLK(cpu_clk),
    .PERIPH_CLK(periph_clk), .RESET_OUT(reset_out), .READY(ready));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("Checks %0d, errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic cpu_falls(input int n);
    repeat (n) @(negedge cpu_clk);
    ticks(1);
  endtask

  // Monitor is parked one cycle before reset so the sys_rst edge cannot race it
  task automatic do_reset(input logic s);
    ticks(1);
    mon_on = 1'b0;
    ticks(1);
    sys_rst = 1'b1;
    strap = s;
    ticks(20);
    check({cpu_clk, periph_clk, reset_out, ready, osc_out, xtal_b}, 6'h09);
    sys_rst = 1'b0;
    ticks(2);
    mon_on = 1'b1;
  endtask

  task automatic set_bus(input logic a, input logic b, input logic oa, input logic ob);
    @(negedge ref_clk);
    {want_a, want_b, off_a, off_b} <= {a, b, oa, ob};
  endtask

  function automatic logic pick(input logic [1:0] sel);
    if (sel == 2'h2) return osc_out;
    return sel[0] ? periph_clk : cpu_clk;
  endfunction

  // High time and period, counted from one rising edge to the next
  task automatic measure(input logic [1:0] sel, output int hi, output int per);
    int n = 0;
    while (pick(sel) !== 1'b0 && n < 999) begin
      ticks(1);
      n++;
    end
    while (pick(sel) !== 1'b1 && n < 999) begin
      ticks(1);
      n++;
    end
    for (hi = 0; pick(sel) === 1'b1 && hi < 999; hi++) ticks(1);
    for (per = hi; pick(sel) === 1'b0 && per < 999; per++) ticks(1);
  endtask

  task automatic freq(input int h);
    int hi, per;
    measure(1'b0, hi, per);
    check(hi, 2 * h);
    check(per, 6 * h);
    measure(1'b1, hi, per);
    check(hi, 6 * h);
    check(per, 12 * h);
    // Buffered oscillator follows the crystal whatever the strap says
    measure(2'h2, hi, per);
    check(hi, XH);
    check(per, 2 * XH);
  endtask

  // Reset and ready outputs may only move where the processor clock falls
  always @(negedge ref_clk) begin
    if (mon_on && reset_out !== prev_rst) check({prev_cpu, cpu_clk}, 2'h2);
    if (mon_on && ready !== prev_rdy) check({prev_cpu, cpu_clk}, 2'h2);
    if (mon_on) check(xtal_b, !osc_out);
    prev_cpu <= cpu_clk;
    prev_rst <= reset_out;
    prev_rdy <= ready;
  end

  // Run is a few thousand cycles; twenty thousand means something hung
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    int n;
    logic seen;
    do_reset(1'b1);
    ticks(300);
    freq(EH);
    do_reset(1'b0);
    ticks(100);
    freq(XH);
    for (int i = 0; i < 16; i++) begin
      set_bus(i[0], i[1], i[2], i[3]);
      cpu_falls(2);
      check(ready, (i[0] & ~i[2]) | (i[1] & ~i[3]));
    end
    for (int m = 0; m < 2; m++) begin
      stage = m[0];
      set_bus(1'b0, 1'b0, 1'b0, 1'b0);
      cpu_falls(2);
      @(posedge cpu_clk);
      set_bus(1'b0, 1'b1, 1'b0, 1'b0);
      cpu_falls(1);
      check(ready, m[0]);
      cpu_falls(1);
      check(ready, 1'b1);
      set_bus(1'b0, 1'b0, 1'b0, 1'b0);
      cpu_falls(1);
      check(ready, 1'b0);
    end
    res_n = 1'b0;
    cpu_falls(2);
    check(reset_out, 1'b1);
    res_n = 1'b1;
    cpu_falls(2);
    check(reset_out, 1'b0);
    clear = 1'b1;
    ticks(6);
    seen = 1'b0;
    repeat (60) begin
      seen = seen | cpu_clk | periph_clk;
      ticks(1);
    end
    check(seen, 1'b0);
    clear = 1'b0;
    for (n = 0; cpu_clk !== 1'b1 && n < 30; n++) ticks(1);
    check(cpu_clk, 1'b1);
    complete_run();
  end
endmodule
